// ---- core/mbtfs_defs.svh ----
`ifndef MBTFS_DEFS_SVH
`define MBTFS_DEFS_SVH

// ***************************************
// frame layout
// ***************************************
`define MBTFS_HDR_BYTES  9'h006
`define MBTFS_REQ_END    9'h00c
`define MBTFS_RTU_MIN    9'h008
`define MBTFS_RC_RTU     9'h006
`define MBTFS_IX_LENHI   9'h004
`define MBTFS_IX_LENLO   9'h005
`define MBTFS_IX_STA     9'h006
`define MBTFS_IX_FC      9'h007
`define MBTFS_IX_BC      9'h008
`define MBTFS_IX_DATA    9'h009
`define MBTFS_RTU_FIXED  8'h03
`define MBTFS_CNT_MAX    9'h1ff

// ***************************************
// station and function codes
// ***************************************
`define MBTFS_STA_BCAST  8'h00
`define MBTFS_STA_MAX    8'hf7
`define MBTFS_FC_NONE    8'h00
`define MBTFS_FC_ERR     8'h80
`define MBTFS_FC_RD_COIL 8'h01
`define MBTFS_FC_RD_DIN  8'h02
`define MBTFS_FC_RD_HOLD 8'h03
`define MBTFS_FC_RD_INP  8'h04
`define MBTFS_FC_WR_COIL 8'h05
`define MBTFS_FC_WR_REG  8'h06
`define MBTFS_FC_WR_MCOL 8'h0f
`define MBTFS_FC_WR_MREG 8'h10

// ***************************************
// exception codes
// ***************************************
`define MBTFS_EX_FUNC    8'h01
`define MBTFS_EX_ADDR    8'h02
`define MBTFS_EX_VALUE   8'h03

`endif

// ---- core/mbtfs_pkg.sv ----
package mbtfs_pkg;

   // six-byte frame header
   typedef struct packed {
      logic [15:0] tid;
      logic [15:0] pid;
      logic [15:0] len;
   } mbtfs_hdr_t;

   // first six rtu bytes of a query
   typedef struct packed {
      logic [7:0]  station_address;
      logic [7:0]  func;
      logic [15:0] start;
      logic [15:0] count;
   } mbtfs_req_t;

   typedef enum logic [1:0] {
      ST_RECV = 2'b00,
      ST_EVAL = 2'b01,
      ST_SEND = 2'b10
   } mbtfs_state_t;

endpackage

// ---- core/mbtfs_coil_packer.sv ----
`timescale 1ns/100ps
`include "mbtfs_defs.svh"

module mbtfs_coil_packer #(
   parameter int N_COILS = 16
) (
   input  wire logic [N_COILS-1:0] coils,
   input  wire logic [15:0]        start,
   input  wire logic [15:0]        count,
   input  wire logic [7:0]         byte_num,
   output logic      [7:0]         packed_byte
);

   // ***************************************
   // one data byte of a coil read
   // ***************************************
   for (genvar b = 0; b < 8; b++) begin : g_bit
      logic [31:0] off;
      logic [31:0] pos;
      assign off = {21'h0, byte_num, 3'(b)};
      assign pos = {16'h0, start} + off;
      assign packed_byte[b] = (off < {16'h0, count} && pos < N_COILS) ? coils[pos] : 1'b0;
   end

endmodule

// ---- core/mbtfs_frame_server.sv ----
`timescale 1ns/100ps
`include "mbtfs_defs.svh"


module mbtfs_frame_server #(
   parameter int N_COILS    = 16,
   parameter int MAX_POINTS = 2000
) (
   input  wire logic                CLK_SYS,
   input  wire logic                RST_N,
   input  wire logic [7:0]          MY_STATION,
   input  wire logic [N_COILS-1:0]  COIL_STATE,
   input  wire logic                RX_VALID,
   input  wire logic [7:0]          RX_DATA,
   input  wire logic                RX_LAST,
   output logic                     RX_READY,
   output logic                     TX_VALID,
   output logic      [7:0]          TX_DATA,
   output logic                     TX_LAST,
   input  wire logic                TX_READY,
   output logic                     CMD_VALID,
   output mbtfs_pkg::mbtfs_hdr_t    CMD_HDR,
   output mbtfs_pkg::mbtfs_req_t    CMD_REQ
);

   // ***************************************
   // elaboration checks
   // ***************************************
   if (N_COILS < 1 || N_COILS > 65536) begin : g_chk_n
      $error("N_COILS out of range");
   end
   if (MAX_POINTS < 1 || MAX_POINTS > 2000) begin : g_chk_m
      $error("MAX_POINTS out of range");
   end

   // ***************************************
   // functions
   // ***************************************
   // supported codes
   function automatic logic fc_supported(input logic [7:0] fc);
      case (fc)
         `MBTFS_FC_RD_COIL, `MBTFS_FC_RD_DIN,  `MBTFS_FC_RD_HOLD,
         `MBTFS_FC_RD_INP,  `MBTFS_FC_WR_COIL, `MBTFS_FC_WR_REG,
         `MBTFS_FC_WR_MCOL, `MBTFS_FC_WR_MREG: fc_supported = 1'b1;
         default: fc_supported = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] coil_bytes(input logic [15:0] pts);
      logic [16:0] sum;
      sum = {1'b0, pts} + 17'h00007;
      coil_bytes = sum[10:3];
   endfunction

   // ***************************************
   // state
   // ***************************************
   mbtfs_pkg::mbtfs_state_t state_q, state_d;
   mbtfs_pkg::mbtfs_hdr_t   hdr_q, hdr_d;
   mbtfs_pkg::mbtfs_req_t   req_q, req_d;
   logic [8:0]  rx_cnt_q, rx_cnt_d;
   logic [8:0]  tx_idx_q, tx_idx_d;
   logic        exc_q, exc_d;
   logic [7:0]  code_q, code_d;
   logic        cmd_vld_q, cmd_vld_d;
   logic [7:0]  tx_data_q, tx_data_d;
   logic [7:0]  pack_byte;
   logic [7:0]  bc;
   logic [8:0]  total;
   logic [8:0]  rtu_n;
   logic [16:0] span;
   logic        frame_ok;
   logic        for_me;
   logic        answer;

   assign bc    = coil_bytes(req_q.count);
   assign rtu_n = rx_cnt_q - `MBTFS_HDR_BYTES;
   assign span  = {1'b0, req_q.start} + {1'b0, req_q.count};
   assign total = `MBTFS_HDR_BYTES + {1'b0, `MBTFS_RTU_FIXED}
                + (exc_q ? 9'h000 : {1'b0, bc});

   assign frame_ok = hdr_q.pid == 16'h0000
                  && hdr_q.len[15:8] == 8'h00
                  && {1'b0, hdr_q.len[7:0]} == rtu_n
                  && rx_cnt_q >= `MBTFS_RTU_MIN + `MBTFS_HDR_BYTES - 9'h006
                  && req_q.station_address <= `MBTFS_STA_MAX
                  && req_q.func != `MBTFS_FC_NONE;
   assign for_me = req_q.station_address == MY_STATION
                || req_q.station_address == `MBTFS_STA_BCAST;
   // broadcasts are never answered; only handed-off codes act on them, broadcast coil reads do nothing
   assign answer = req_q.station_address != `MBTFS_STA_BCAST;

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      state_d   = state_q;
      hdr_d     = hdr_q;
      req_d     = req_q;
      rx_cnt_d  = rx_cnt_q;
      tx_idx_d  = tx_idx_q;
      exc_d     = exc_q;
      code_d    = code_q;
      cmd_vld_d = 1'b0;
      case (state_q)
         mbtfs_pkg::ST_RECV: begin
            if (RX_VALID) begin
               if (rx_cnt_q != `MBTFS_CNT_MAX) begin
                  rx_cnt_d = rx_cnt_q + 9'h001;
               end
               if (rx_cnt_q < `MBTFS_HDR_BYTES) begin
                  hdr_d = {hdr_q[39:0], RX_DATA};
               end else if (rx_cnt_q < `MBTFS_REQ_END) begin
                  req_d = {req_q[39:0], RX_DATA};
               end
               if (rx_cnt_q == 9'h000) begin
                  req_d = '0;
               end
               if (RX_LAST) begin
                  state_d = mbtfs_pkg::ST_EVAL;
               end
            end
         end
         mbtfs_pkg::ST_EVAL: begin
            rx_cnt_d = 9'h000;
            tx_idx_d = 9'h000;
            exc_d    = 1'b0;
            code_d   = 8'h00;
            state_d  = mbtfs_pkg::ST_RECV;
            if (frame_ok && for_me) begin
               if (req_q.func == `MBTFS_FC_RD_COIL) begin
                  if (rtu_n != `MBTFS_RC_RTU || req_q.count == 16'h0000
                      || {16'h0, req_q.count} > MAX_POINTS) begin
                     exc_d  = 1'b1;
                     code_d = `MBTFS_EX_VALUE;
                  end else if ({15'h0, span} > N_COILS) begin
                     exc_d  = 1'b1;
                     code_d = `MBTFS_EX_ADDR;
                  end
                  if (answer) begin
                     state_d = mbtfs_pkg::ST_SEND;
                  end
               end else if (fc_supported(req_q.func)) begin
                  cmd_vld_d = 1'b1;
               end else if (answer) begin
                  exc_d   = 1'b1;
                  code_d  = `MBTFS_EX_FUNC;
                  state_d = mbtfs_pkg::ST_SEND;
               end
            end
         end
         mbtfs_pkg::ST_SEND: begin
            if (TX_READY) begin
               if (TX_LAST) begin
                  state_d = mbtfs_pkg::ST_RECV;
               end else begin
                  tx_idx_d = tx_idx_q + 9'h001;
               end
            end
         end
         default: begin
            state_d = mbtfs_pkg::ST_RECV;
         end
      endcase
   end

   // ***************************************
   // reply byte for the next index
   // ***************************************
   mbtfs_coil_packer #(
      .N_COILS (N_COILS)
   ) u_pack (
      .coils       (COIL_STATE),
      .start       (req_q.start),
      .count       (req_q.count),
      .byte_num    (8'(tx_idx_d - `MBTFS_IX_DATA)),
      .packed_byte (pack_byte)
   );

   always_comb begin
      case (tx_idx_d)
         9'h000: tx_data_d = hdr_q.tid[15:8];
         9'h001: tx_data_d = hdr_q.tid[7:0];
         9'h002: tx_data_d = hdr_q.pid[15:8];
         9'h003: tx_data_d = hdr_q.pid[7:0];
         `MBTFS_IX_LENHI: tx_data_d = 8'h00;
         `MBTFS_IX_LENLO: tx_data_d = exc_d ? `MBTFS_RTU_FIXED : `MBTFS_RTU_FIXED + bc;
         `MBTFS_IX_STA: tx_data_d = req_q.station_address;
         `MBTFS_IX_FC: tx_data_d = exc_d ? (req_q.func | `MBTFS_FC_ERR) : req_q.func;
         `MBTFS_IX_BC: tx_data_d = exc_d ? code_d : bc;
         default: tx_data_d = pack_byte;
      endcase
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_q   <= mbtfs_pkg::ST_RECV;
         hdr_q     <= '0;
         req_q     <= '0;
         rx_cnt_q  <= 9'h000;
         tx_idx_q  <= 9'h000;
         exc_q     <= 1'b0;
         code_q    <= 8'h00;
         cmd_vld_q <= 1'b0;
         tx_data_q <= 8'h00;
      end else begin
         state_q   <= state_d;
         hdr_q     <= hdr_d;
         req_q     <= req_d;
         rx_cnt_q  <= rx_cnt_d;
         tx_idx_q  <= tx_idx_d;
         exc_q     <= exc_d;
         code_q    <= code_d;
         cmd_vld_q <= cmd_vld_d;
         tx_data_q <= tx_data_d;
      end
   end

   // ***************************************
   // outputs
   // ***************************************
   assign RX_READY  = state_q == mbtfs_pkg::ST_RECV;
   assign TX_VALID  = state_q == mbtfs_pkg::ST_SEND;
   assign TX_DATA   = tx_data_q;
   assign TX_LAST   = TX_VALID && tx_idx_q == total - 9'h001;
   assign CMD_VALID = cmd_vld_q;
   assign CMD_HDR   = hdr_q;
   assign CMD_REQ   = req_q;

   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   property p_echo_fc;
      TX_VALID && tx_idx_q == `MBTFS_IX_FC && !exc_q |-> TX_DATA == req_q.func;
   endproperty
   a_echo_fc: assert property (p_echo_fc) else $error("fc not echoed");

   property p_err_msb;
      TX_VALID && tx_idx_q == `MBTFS_IX_FC |-> TX_DATA[7] == exc_q;
   endproperty
   a_err_msb: assert property (p_err_msb) else $error("fc msb wrong");

   property p_tid_echo;
      TX_VALID && tx_idx_q == 9'h001 |-> TX_DATA == hdr_q.tid[7:0];
   endproperty
   a_tid_echo: assert property (p_tid_echo) else $error("tid not echoed");

   property p_len_hi;
      TX_VALID && tx_idx_q == `MBTFS_IX_LENHI |-> TX_DATA == 8'h00;
   endproperty
   a_len_hi: assert property (p_len_hi) else $error("length hi nonzero");

   property p_len_lo;
      TX_VALID && tx_idx_q == `MBTFS_IX_LENLO |-> {1'b0, TX_DATA} == total - 9'h006;
   endproperty
   a_len_lo: assert property (p_len_lo) else $error("length lo wrong");

   property p_byte_cnt;
      TX_VALID && tx_idx_q == `MBTFS_IX_BC && !exc_q
         |-> TX_DATA == 8'((req_q.count + 16'h0007) >> 3);
   endproperty
   a_byte_cnt: assert property (p_byte_cnt) else $error("byte count wrong");

   property p_coil_exc;
      TX_VALID && exc_q && req_q.func == `MBTFS_FC_RD_COIL
         |-> total == 9'h009 && code_q inside {`MBTFS_EX_ADDR, `MBTFS_EX_VALUE};
   endproperty
   a_coil_exc: assert property (p_coil_exc) else $error("coil exception bad");

   property p_unsup;
      state_q == mbtfs_pkg::ST_EVAL && frame_ok && for_me && answer
         && !fc_supported(req_q.func)
         |=> exc_q && code_q == `MBTFS_EX_FUNC && TX_VALID;
   endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported not refused");

   property p_query_first;
      $rose(TX_VALID) |-> $past(state_q) == mbtfs_pkg::ST_EVAL && $past(RX_LAST, 2);
   endproperty
   a_query_first: assert property (p_query_first) else $error("reply without query");

   property p_station;
      TX_VALID |-> req_q.station_address != `MBTFS_STA_BCAST
                && req_q.station_address <= `MBTFS_STA_MAX;
   endproperty
   a_station: assert property (p_station) else $error("bad station answered");

   c_normal: cover property (TX_LAST && TX_READY && !exc_q);
   c_coil_exc: cover property (TX_LAST && TX_READY && exc_q && code_q == `MBTFS_EX_ADDR);
   c_unsup: cover property (TX_LAST && TX_READY && code_q == `MBTFS_EX_FUNC);
   c_handoff: cover property (CMD_VALID);

endmodule

// ---- testbench/mbtfs_master_model.sv ----
`timescale 1ns/100ps

// ***************************************
// query source and reply sink of the remote master
// ***************************************
module mbtfs_master_model (
   input  wire logic       clk,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_last,
   input  wire logic       rx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready
);
   logic [7:0] reply[$];
   int         timeouts = 0;

   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_last  = 1'b0;
      tx_ready = 1'b1;
   end

   // idle data line inverts every cycle, so no byte is held steady
   always @(posedge clk) begin
      if (!rx_valid) begin
         rx_data <= ~rx_data;
      end
   end

   task automatic send(input logic [7:0] f[$]);
      int w;
      foreach (f[i]) begin
         rx_valid = 1'b1;
         rx_data  = f[i];
         rx_last  = (i == f.size() - 1);
         w = 0;
         while (rx_ready !== 1'b1 && w < 200) begin
            @(posedge clk);
            #1;
            w++;
         end
         if (w >= 200) timeouts++;
         @(posedge clk);
         #1;
      end
      rx_valid = 1'b0;
      rx_last  = 1'b0;
   endtask

   // collect one reply, optionally holding off every other cycle
   task automatic recv(input bit stall);
      int w;
      bit done;
      reply.delete();
      w = 0;
      done = 0;
      while (!done && w < 300) begin
         tx_ready = stall ? w[0] : 1'b1;
         if (tx_valid === 1'b1 && tx_ready) begin
            reply.push_back(tx_data);
            done = (tx_last === 1'b1);
         end
         @(posedge clk);
         #1;
         w++;
      end
      tx_ready = 1'b1;
      if (!done) timeouts++;
   endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/100ps

module tb;
   logic                  clk_sys = 1'b0;
   logic                  rst_n = 1'b0;
   logic [7:0]            my_sta = 8'h01;
   logic [15:0]           coils = 16'h0000;
   logic                  rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, cmd_valid;
   logic [7:0]            rx_data, tx_data;
   mbtfs_pkg::mbtfs_hdr_t cmd_hdr;
   mbtfs_pkg::mbtfs_req_t cmd_req;
   int                    n_errors = 0;
   int                    samples_checked = 0;
   logic [7:0]            q[$];
   logic [7:0]            e[$];

   always #50 clk_sys = ~clk_sys;

   mbtfs_frame_server #(.N_COILS(16), .MAX_POINTS(2000)) mbtfs_frame_server_inst (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .MY_STATION(my_sta), .COIL_STATE(coils),
      .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_READY(rx_ready),
      .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready),
      .CMD_VALID(cmd_valid), .CMD_HDR(cmd_hdr), .CMD_REQ(cmd_req));

   mbtfs_master_model mbtfs_master_model_inst (
      .clk(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_ready(tx_ready));

   // ***************************************
   // compare and report
   // ***************************************
   task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   task automatic chk_wide(input logic [47:0] exp, input logic [47:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      n_errors += mbtfs_master_model_inst.timeouts;
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // start and count high byte first
   task automatic mk(input logic [15:0] tid, pid, len, input logic [7:0] sta, fc,
                     input logic [15:0] st, cnt);
      q = '{tid[15:8], tid[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0],
            sta, fc, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
   endtask

   task automatic chk_reply(input bit stall);
      mbtfs_master_model_inst.recv(stall);
      chk_byte(8'(e.size()), 8'(mbtfs_master_model_inst.reply.size()));
      foreach (e[i]) begin
         if (i < mbtfs_master_model_inst.reply.size()) begin
            chk_byte(e[i], mbtfs_master_model_inst.reply[i]);
         end
      end
      chk_byte(8'h01, {7'h00, rx_ready});
   endtask

   // ***************************************
   // scenarios
   // ***************************************
   task automatic run_read(input logic [15:0] tid, st, cnt, input bit stall);
      logic [7:0] d;
      int n;
      n = (cnt + 7) / 8;
      mk(tid, 16'h0000, 16'h0006, my_sta, 8'h01, st, cnt);
      mbtfs_master_model_inst.send(q);
      e = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(3 + n), my_sta, 8'h01, 8'(n)};
      for (int m = 0; m < n; m++) begin
         for (int b = 0; b < 8; b++) begin
            d[b] = (8 * m + b < cnt) ? coils[st + 8 * m + b] : 1'b0;
         end
         e.push_back(d);
      end
      chk_reply(stall);
   endtask

   task automatic t_coil_reads();
      my_sta = 8'h01;
      coils = 16'h001f;
      run_read(16'h0102, 16'h0000, 16'h0005, 1'b0);
      my_sta = 8'hf7;
      coils = 16'ha5c3;
      run_read(16'hbeef, 16'h0003, 16'h000a, 1'b1);
      run_read(16'h0007, 16'h0000, 16'h0010, 1'b1);
      run_read(16'h0008, 16'h000f, 16'h0001, 1'b0);
      run_read(16'h0009, 16'h0004, 16'h0008, 1'b0);
      $display("test coil_reads done, errors %0d", n_errors);
   endtask

   task automatic t_exceptions();
      logic [7:0]  fc[5] = '{8'h07, 8'h2b, 8'h01, 8'h01, 8'h01};
      logic [15:0] st[5] = '{16'h0000, 16'h0000, 16'h000a, 16'h0000, 16'h0000};
      logic [15:0] ct[5] = '{16'h0001, 16'h0001, 16'h0007, 16'h0000, 16'h07d1};
      logic [7:0]  ex[5] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h03};
      for (int i = 0; i < 5; i++) begin
         mk(16'h3300 + 16'(i), 16'h0000, 16'h0006, my_sta, fc[i], st[i], ct[i]);
         mbtfs_master_model_inst.send(q);
         e = '{8'h33, 8'(i), 8'h00, 8'h00, 8'h00, 8'h03, my_sta, fc[i] | 8'h80, ex[i]};
         chk_reply(1'b0);
      end
      $display("test exceptions done, errors %0d", n_errors);
   endtask

   task automatic t_commands();
      logic [7:0] fc[7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
      bit seen;
      for (int i = 0; i < 7; i++) begin
         mk(16'h5a00 + 16'(i), 16'h0000, 16'h0006, my_sta, fc[i], 16'h0102, 16'h0304);
         mbtfs_master_model_inst.send(q);
         seen = 0;
         for (int w = 0; w < 4 && !seen; w++) begin
            seen = (cmd_valid === 1'b1);
            if (!seen) @(posedge clk_sys);
            if (!seen) #1;
         end
         chk_byte(8'h01, {7'h00, seen});
         chk_wide({my_sta, fc[i], 32'h01020304}, cmd_req);
         chk_wide({16'h5a00 + 16'(i), 32'h00000006}, cmd_hdr);
         @(posedge clk_sys);
         #1;
         chk_byte(8'h00, {6'h00, cmd_valid, tx_valid});
      end
      $display("test commands done, errors %0d", n_errors);
   endtask

   task automatic t_dropped();
      logic [7:0]  sta[7] = '{8'h00, 8'h03, 8'hf8, 8'hf7, 8'hf7, 8'hf7, 8'hf7};
      logic [15:0] pid[7] = '{16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0};
      logic [15:0] len[7] = '{16'h6, 16'h6, 16'h6, 16'h6, 16'h106, 16'h7, 16'h6};
      logic [7:0]  fc[7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
      for (int i = 0; i < 7; i++) begin
         mk(16'h7700, pid[i], len[i], sta[i], fc[i], 16'h0000, 16'h0004);
         mbtfs_master_model_inst.send(q);
         repeat (6) begin
            chk_byte(8'h00, {6'h00, cmd_valid, tx_valid});
            @(posedge clk_sys);
            #1;
         end
      end
      $display("test dropped done, errors %0d", n_errors);
   endtask

   task automatic t_station();
      run_read(16'h0abc, 16'h0002, 16'h0003, 1'b0);
      $display("test station done, errors %0d", n_errors);
   endtask

   // ***************************************
   // main sequence and watchdog
   // ***************************************
   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      chk_byte(8'h04, {5'h00, rx_ready, tx_valid, cmd_valid});
      t_coil_reads();
      t_exceptions();
      t_commands();
      t_dropped();
      t_station();
      tally_and_finish();
   end

   initial begin
      #(20000 * 100);
      n_errors++;
      tally_and_finish();
   end
endmodule
